// ---- design/cpc_top.sv ----
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module cpc_top #(
    parameter int unsigned CONV_CYC [8] = cpc_pkg::CONV_CYC_DEF
) (
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire cpc_pkg::cpc_axi_req_t axi_req,
    output var  cpc_pkg::cpc_axi_rsp_t axi_rsp,
    input  wire logic signed [15:0]    shunt_code,
    input  wire logic        [15:0]    bus_code,
    output logic                       input_range_select,
    output logic                       result_ready
);
    import cpc_pkg::*;

    logic [CFG_W-1:0]  cfg_q;
    logic [15:0]       cal_q;
    logic [15:0]       vshunt_q;
    logic [15:0]       vbus_q;
    logic [15:0]       current_q;
    logic [PWR_W-1:0]  power_q;
    logic              ready_q;
    logic              range_q;
    logic              pulse_q;
    logic [17:0]       conv_cnt_q;
    logic [9:0]        avg_cnt_q;
    logic signed [25:0] sh_acc_q;
    logic [25:0]       bus_acc_q;
    logic              div_start_q;
    logic              neg_q;
    logic              cal_zero_q;
    logic [15:0]       vbus_lat_q;
    logic              aw_have_q;
    logic              w_have_q;
    logic              awready_q;
    logic              wready_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [31:0]       rdata_q;
    logic [1:0]        rresp_q;

    logic [2:0]        conv_sel;
    logic [2:0]        avg_sel;
    logic              conv_done;
    logic              group_done;
    logic [9:0]        avg_last;
    logic signed [25:0] sh_sum;
    logic [25:0]       bus_sum;
    logic signed [25:0] sh_avg;
    logic [25:0]       bus_avg;
    logic [DIV_W-1:0]  quot;
    logic              div_done;
    logic [15:0]       cur_mag;
    logic [15:0]       cur_val;
    logic [31:0]       pwr_prod;
    logic [25:0]       pwr_full;
    logic [PWR_W-1:0]  pwr_val;
    logic              do_write;
    logic              ar_take;
    logic              sts_read;

    assign conv_sel = cfg_q[CFG_CONV_LSB +: 3];
    assign avg_sel  = cfg_q[CFG_AVG_LSB +: 3];

    // conversion timer
    assign conv_done = 32'(conv_cnt_q) >= CONV_CYC[conv_sel] - 32'd1;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_cnt_q <= '0;
        end else if (conv_done) begin
            conv_cnt_q <= '0;
        end else begin
            conv_cnt_q <= conv_cnt_q + 18'd1;
        end
    end

    // averaging of shunt and bus samples
    assign avg_last   = 10'((32'd1 << AVG_SHIFT[avg_sel]) - 32'd1);
    assign group_done = conv_done && (avg_cnt_q >= avg_last);
    assign sh_sum     = sh_acc_q + 26'(shunt_code);
    assign bus_sum    = bus_acc_q + 26'(bus_code);
    assign sh_avg     = sh_sum >>> AVG_SHIFT[avg_sel];
    assign bus_avg    = bus_sum >> AVG_SHIFT[avg_sel];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avg_cnt_q <= '0;
            sh_acc_q  <= '0;
            bus_acc_q <= '0;
        end else if (group_done) begin
            avg_cnt_q <= '0;
            sh_acc_q  <= '0;
            bus_acc_q <= '0;
        end else if (conv_done) begin
            avg_cnt_q <= avg_cnt_q + 10'd1;
            sh_acc_q  <= sh_sum;
            bus_acc_q <= bus_sum;
        end
    end

    // latch averages and launch the current division
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vshunt_q    <= '0;
            vbus_q      <= '0;
            vbus_lat_q  <= '0;
            div_start_q <= 1'b0;
            neg_q       <= 1'b0;
            cal_zero_q  <= 1'b0;
        end else begin
            div_start_q <= group_done;
            if (group_done) begin
                vshunt_q   <= sh_avg[15:0];
                vbus_q     <= bus_avg[15:0];
                vbus_lat_q <= bus_avg[15:0];
                neg_q      <= sh_avg[15];
                cal_zero_q <= cal_q == 16'h0000;
            end
        end
    end

    // current = shunt * 4096 / scale
    cpc_div #(
        .DW (DIV_W),
        .VW (16)
    ) u_div (
        .clk      (clk),
        .rst_b    (rst_b),
        .start    (div_start_q),
        .dividend ({DIV_W'(vshunt_q[15] ? 16'(-vshunt_q) : vshunt_q)}
                   << CUR_SHIFT),
        .divisor  (cal_q),
        .quot     (quot),
        .done     (div_done)
    );

    // saturate to signed 16 bits; zero scale gives zero
    always_comb begin
        cur_mag = '0;
        cur_val = '0;
        if (cal_zero_q) begin
            cur_mag = 16'h0000;
            cur_val = 16'h0000;
        end else if (neg_q) begin
            cur_mag = (quot > DIV_W'(32768)) ? 16'h8000 : quot[15:0];
            cur_val = 16'(-cur_mag);
        end else begin
            cur_mag = (quot > DIV_W'(32767)) ? 16'h7FFF : quot[15:0];
            cur_val = cur_mag;
        end
    end

    // power = |current| * bus / 64, saturated to 24 bits
    assign pwr_prod = 32'(cur_mag) * 32'(vbus_lat_q);
    assign pwr_full = pwr_prod[PWR_SHIFT +: 26];
    assign pwr_val  = (pwr_full[25:PWR_W] != 2'b00) ? {PWR_W{1'b1}}
                                                    : pwr_full[PWR_W-1:0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            current_q <= '0;
            power_q   <= '0;
            pulse_q   <= 1'b0;
        end else begin
            pulse_q <= div_done;
            if (div_done) begin
                current_q <= cur_val;
                power_q   <= pwr_val;
            end
        end
    end

    // ready flag: set wins over read clear
    assign sts_read = ar_take && (axi_req.araddr == OFS_STATUS);

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_q <= 1'b0;
        end else if (div_done) begin
            ready_q <= 1'b1;
        end else if (sts_read) begin
            ready_q <= 1'b0;
        end
    end

    // write channel
    assign do_write = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
        end else begin
            if (axi_req.awvalid && awready_q) begin
                aw_have_q <= 1'b1;
                awready_q <= 1'b0;
                awaddr_q  <= axi_req.awaddr;
            end
            if (axi_req.wvalid && wready_q) begin
                w_have_q <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= axi_req.wdata;
                wstrb_q  <= axi_req.wstrb;
            end
            if (do_write) begin
                bvalid_q <= 1'b1;
                bresp_q  <= (awaddr_q == OFS_CONFIG || awaddr_q == OFS_CAL)
                            ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_q && axi_req.bready) begin
                bvalid_q  <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    // writable registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= CFG_RST;
            cal_q <= CAL_RST;
        end else if (do_write) begin
            if (awaddr_q == OFS_CONFIG && wstrb_q[0]) begin
                cfg_q <= wdata_q[CFG_W-1:0];
            end
            if (awaddr_q == OFS_CAL) begin
                if (wstrb_q[0]) begin
                    cal_q[7:0] <= wdata_q[7:0];
                end
                if (wstrb_q[1]) begin
                    cal_q[15:8] <= wdata_q[15:8];
                end
            end
        end
    end

    // range select drives the analog front end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            range_q <= 1'b0;
        end else begin
            range_q <= cfg_q[CFG_RANGE];
        end
    end

    // read channel
    assign ar_take = axi_req.arvalid && arready_q;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rdata_q   <= '0;
            rresp_q   <= RESP_OKAY;
        end else if (ar_take) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= RESP_OKAY;
            case (axi_req.araddr)
                OFS_CONFIG:  rdata_q <= 32'(cfg_q);
                OFS_CAL:     rdata_q <= 32'(cal_q);
                OFS_VSHUNT:  rdata_q <= 32'(vshunt_q);
                OFS_VBUS:    rdata_q <= 32'(vbus_q);
                OFS_CURRENT: rdata_q <= 32'(current_q);
                OFS_POWER:   rdata_q <= 32'(power_q);
                OFS_STATUS:  rdata_q <= 32'(ready_q);
                default: begin
                    rdata_q <= '0;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && axi_req.rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    assign axi_rsp.awready = awready_q;
    assign axi_rsp.wready  = wready_q;
    assign axi_rsp.bvalid  = bvalid_q;
    assign axi_rsp.bresp   = bresp_q;
    assign axi_rsp.arready = arready_q;
    assign axi_rsp.rvalid  = rvalid_q;
    assign axi_rsp.rdata   = rdata_q;
    assign axi_rsp.rresp   = rresp_q;
    assign input_range_select = range_q;
    assign result_ready       = pulse_q;
endmodule
`default_nettype wire

// ---- inc/cpc_pkg.sv ----
// Operation
// - after every shunt conversion group a new current is computed from the shunt scale
// - shunt scale of zero forces the current result to zero
// - current result times current step gives amperes
// - 24-bit power result times 0.2 times current step gives watts
// - eight conversion times, 50 to 4120 microseconds, selectable
// - selectable averaging count; one output per averaging group
// - single range-select bit picks wide or narrow shunt input range
`default_nettype none
package cpc_pkg;
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  OFS_CONFIG   = 8'h00;
    localparam logic [7:0]  OFS_CAL      = 8'h04;
    localparam logic [7:0]  OFS_VSHUNT   = 8'h08;
    localparam logic [7:0]  OFS_VBUS     = 8'h0C;
    localparam logic [7:0]  OFS_CURRENT  = 8'h10;
    localparam logic [7:0]  OFS_POWER    = 8'h14;
    localparam logic [7:0]  OFS_STATUS   = 8'h18;
    localparam int          CFG_W        = 7;
    localparam int          CFG_RANGE    = 0;
    localparam int          CFG_CONV_LSB = 1;
    localparam int          CFG_AVG_LSB  = 4;
    localparam logic [6:0]  CFG_RST      = 7'h00;
    localparam logic [15:0] CAL_RST      = 16'h0000;
    localparam int          STS_READY    = 0;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
    localparam int          CLK_MHZ      = 50;
    localparam int unsigned CONV_US [8]  = '{50, 84, 150, 280, 540, 1052,
                                             2074, 4120};
    localparam int unsigned CONV_CYC_DEF [8] = '{
        CONV_US[0] * CLK_MHZ, CONV_US[1] * CLK_MHZ,
        CONV_US[2] * CLK_MHZ, CONV_US[3] * CLK_MHZ,
        CONV_US[4] * CLK_MHZ, CONV_US[5] * CLK_MHZ,
        CONV_US[6] * CLK_MHZ, CONV_US[7] * CLK_MHZ};
    localparam int unsigned AVG_SHIFT [8] = '{0, 2, 4, 6, 7, 8, 9, 10};
    localparam int          CUR_SHIFT    = 12;
    localparam int          PWR_SHIFT    = 6;
    localparam int          PWR_W        = 24;
    localparam int          DIV_W        = 28;

    typedef struct packed {
        logic              awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic              wvalid;
        logic [31:0]       wdata;
        logic [3:0]        wstrb;
        logic              bready;
        logic              arvalid;
        logic [ADDR_W-1:0] araddr;
        logic              rready;
    } cpc_axi_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } cpc_axi_rsp_t;
endpackage
`default_nettype wire

// ---- design/cpc_div.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpc_div #(
    parameter int DW = 28,
    parameter int VW = 16
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic          start,
    input  wire logic [DW-1:0] dividend,
    input  wire logic [VW-1:0] divisor,
    output logic      [DW-1:0] quot,
    output logic               done
);
    localparam int CW = $clog2(DW + 1);

    logic [VW-1:0] rem_q;
    logic [DW-1:0] quo_q;
    logic [VW-1:0] dvs_q;
    logic [CW-1:0] cnt_q;
    logic          busy_q;
    logic          done_q;
    logic [VW:0]   trial;
    logic          fits;

    // restoring division, one quotient bit per clock
    assign trial = {rem_q, quo_q[DW-1]};
    assign fits  = trial >= {1'b0, dvs_q};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rem_q  <= '0;
            quo_q  <= '0;
            dvs_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (start && !busy_q) begin
                rem_q  <= '0;
                quo_q  <= dividend;
                dvs_q  <= divisor;
                cnt_q  <= CW'(DW);
                busy_q <= 1'b1;
            end else if (busy_q) begin
                rem_q  <= fits ? VW'(trial - {1'b0, dvs_q}) : trial[VW-1:0];
                quo_q  <= {quo_q[DW-2:0], fits};
                cnt_q  <= cnt_q - CW'(1);
                if (cnt_q == CW'(1)) begin
                    busy_q <= 1'b0;
                    done_q <= 1'b1;
                end
            end
        end
    end

    assign quot = quo_q;
    assign done = done_q;
endmodule
`default_nettype wire

// ---- tb/cpc_checker.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpc_checker (
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire cpc_pkg::cpc_axi_req_t axi_req,
    input wire cpc_pkg::cpc_axi_rsp_t axi_rsp,
    input wire logic signed [15:0]    shunt_code,
    input wire logic        [15:0]    bus_code,
    input wire logic                  input_range_select,
    input wire logic                  result_ready
);
    import cpc_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic ar_hs = axi_req.arvalid && axi_rsp.arready;
    wire logic wr_hs = axi_req.awvalid && axi_rsp.awready
                       && axi_req.wvalid && axi_rsp.wready;
    wire logic cfg_wr = wr_hs && axi_req.awaddr == OFS_CONFIG
                        && axi_req.wstrb[0];
    sequence s_rd(a);
        ar_hs && axi_req.araddr == a ##1 axi_rsp.rvalid;
    endsequence
    property p_range_follow;
        logic b;
        (cfg_wr, b = axi_req.wdata[0]) |-> ##3 input_range_select == b;
    endproperty
    property p_wr_answer;
        wr_hs |=> !axi_rsp.bvalid ##1 axi_rsp.bvalid;
    endproperty
    property p_rd_answer;
        ar_hs |=> axi_rsp.rvalid;
    endproperty
    property p_busy;
        (axi_rsp.bvalid |-> !axi_rsp.awready && !axi_rsp.wready)
        and (axi_rsp.rvalid |-> !axi_rsp.arready);
    endproperty
    property p_power_width;
        s_rd(OFS_POWER) |-> axi_rsp.rdata[31:24] == 8'h00;
    endproperty
    property p_current_width;
        s_rd(OFS_CURRENT) |-> axi_rsp.rdata[31:16] == 16'h0000;
    endproperty
    property p_unmapped;
        ar_hs && axi_req.araddr > OFS_STATUS |=>
            axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0;
    endproperty
    property p_pulse;
        result_ready |=> !result_ready;
    endproperty
    a_range_follow: assert property (p_range_follow)
        else $error("range select does not follow config write");
    a_wr_answer: assert property (p_wr_answer)
        else $error("write response not on time");
    a_rd_answer: assert property (p_rd_answer)
        else $error("read response not on time");
    a_busy: assert property (p_busy)
        else $error("ready high while response pending");
    a_power_width: assert property (p_power_width)
        else $error("power result wider than 24 bits");
    a_current_width: assert property (p_current_width)
        else $error("current result upper bits set");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    a_pulse: assert property (p_pulse)
        else $error("result ready longer than one cycle");
endmodule
bind cpc_top cpc_checker chk_u (
    .clk(clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
    .shunt_code(shunt_code), .bus_code(bus_code),
    .input_range_select(input_range_select), .result_ready(result_ready));
`default_nettype wire

// ---- tb/cpc_host.sv ----
`timescale 1ns/10ps
`default_nettype none
module cpc_host (
    input  wire logic                  clk,
    output var  cpc_pkg::cpc_axi_req_t req,
    input  wire cpc_pkg::cpc_axi_rsp_t rsp
);
    import cpc_pkg::*;
    initial begin
        req = '0;
        req.bready = 1'b1;
        req.rready = 1'b1;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [1:0] r);
        req.awvalid <= 1'b1;
        req.awaddr  <= a;
        req.wvalid  <= 1'b1;
        req.wdata   <= d;
        req.wstrb   <= s;
        fork
            begin
                do @(posedge clk); while (!rsp.awready);
                req.awvalid <= 1'b0;
            end
            begin
                do @(posedge clk); while (!rsp.wready);
                req.wvalid <= 1'b0;
            end
        join
        do @(posedge clk); while (!rsp.bvalid);
        r = rsp.bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        req.arvalid <= 1'b1;
        req.araddr  <= a;
        do @(posedge clk); while (!rsp.arready);
        req.arvalid <= 1'b0;
        do @(posedge clk); while (!rsp.rvalid);
        d = rsp.rdata;
        r = rsp.rresp;
    endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import cpc_pkg::*;
    localparam int unsigned CC [8] = '{40, 50, 60, 70, 80, 90, 100, 110};
    localparam logic [15:0] CAL [4] = '{16'h0800, 16'h0800, 16'h2000, 16'h0001};
    localparam logic [15:0] VSH [4] = '{16'h03E8, 16'hFC18, 16'h0FA0, 16'h7FFF};
    localparam logic [15:0] VBS [4] = '{16'h0280, 16'h0280, 16'h0280, 16'hFFFF};
    localparam logic [31:0] CUR [4] = '{32'h07D0, 32'hF830, 32'h07D0, 32'h7FFF};
    localparam logic [31:0] PWR [4] = '{32'h4E20, 32'h4E20, 32'h4E20, 32'hFFFFFF};
    logic               clk = 1'b0;
    logic               rst_b = 1'b0;
    logic signed [15:0] shunt_code = 16'h0000;
    logic        [15:0] bus_code = 16'h0000;
    cpc_axi_req_t       axi_req;
    cpc_axi_rsp_t       axi_rsp;
    logic               range_sel;
    logic               res_rdy;
    int                 miscompares = 0;
    int                 checked = 0;
    int                 n;
    logic [31:0]        d;
    logic [1:0]         r;
    logic [2:0]         cv;
    logic [2:0]         av;
    always #10 clk = ~clk;
    cpc_host host_u (.clk(clk), .req(axi_req), .rsp(axi_rsp));
    cpc_top #(.CONV_CYC(CC)) dut_u (
        .clk(clk), .rst_b(rst_b), .axi_req(axi_req), .axi_rsp(axi_rsp),
        .shunt_code(shunt_code), .bus_code(bus_code),
        .input_range_select(range_sel), .result_ready(res_rdy));
    task automatic test_done;
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        host_u.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wr_chk(input logic [7:0] a, input logic [31:0] v,
                          input logic [3:0] s, input logic [1:0] er);
        host_u.wr(a, v, s, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wait_res;
        do @(posedge clk); while (res_rdy !== 1'b1);
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        test_done();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        chk({31'h0, range_sel}, 32'h0);
        rd_chk(OFS_CONFIG, 32'h0, RESP_OKAY);
        rd_chk(OFS_CAL, 32'h0, RESP_OKAY);
        rd_chk(8'h40, 32'h0, RESP_SLVERR);
        wr_chk(OFS_CURRENT, 32'h1234, 4'hF, RESP_SLVERR);
        shunt_code <= 16'h03E8;
        bus_code <= 16'h0280;
        wait_res();
        wait_res();
        rd_chk(OFS_CURRENT, 32'h0, RESP_OKAY);
        rd_chk(OFS_POWER, 32'h0, RESP_OKAY);
        // cal = 819.2e6 * step * shunt, step = max / 2**15, x4 when narrow
        for (int i = 0; i < 4; i++) begin
            wr_chk(OFS_CONFIG, {31'h0, i == 2}, 4'h1, RESP_OKAY);
            wr_chk(OFS_CAL, {16'h0, CAL[i]}, 4'h3, RESP_OKAY);
            shunt_code <= VSH[i];
            bus_code <= VBS[i];
            wait_res();
            wait_res();
            chk({31'h0, range_sel}, {31'h0, i == 2});
            rd_chk(OFS_CURRENT, CUR[i], RESP_OKAY);
            rd_chk(OFS_POWER, PWR[i], RESP_OKAY);
        end
        for (int i = 0; i < 10; i++) begin
            cv = (i < 8) ? 3'(i) : 3'h0;
            av = (i < 8) ? 3'h0 : 3'(i - 7);
            wr_chk(OFS_CONFIG, {25'h0, av, cv, 1'b0}, 4'h1, RESP_OKAY);
            wait_res();
            wait_res();
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (res_rdy !== 1'b1);
            chk(32'(n), CC[cv] << (2 * av));
        end
        rd_chk(OFS_VSHUNT, 32'h7FFF, RESP_OKAY);
        rd_chk(OFS_VBUS, 32'hFFFF, RESP_OKAY);
        rd_chk(OFS_CONFIG, 32'h20, RESP_OKAY);
        wait_res();
        rd_chk(OFS_STATUS, 32'h1, RESP_OKAY);
        rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
        // low lane only: upper scale byte keeps its old zero
        wr_chk(OFS_CAL, 32'h12AB, 4'h1, RESP_OKAY);
        rd_chk(OFS_CAL, 32'hAB, RESP_OKAY);
        // full negative shunt saturates current and power
        shunt_code <= 16'h8000;
        wait_res();
        wait_res();
        rd_chk(OFS_VSHUNT, 32'h8000, RESP_OKAY);
        rd_chk(OFS_CURRENT, 32'h8000, RESP_OKAY);
        rd_chk(OFS_POWER, 32'hFFFFFF, RESP_OKAY);
        test_done();
    end
endmodule
`default_nettype wire
